//--- dmc_ctrl.sv
// Host controller that programs DDR3 mode registers one and two and waits for DLL lock
`include "dmc_defs.svh"
module dmc_ctrl #(
    parameter int LOCK_CYCLES = `DMC_DLL_LOCK_TIME
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            ce,
    // User request
    input  wire logic            start,
    input  wire dmc_pkg::dmc_cfg_s cfg,
    input  wire logic [3:0]      cas_latency,
    output logic                 busy,
    output logic                 ready,
    output logic [4:0]           read_latency,
    output logic [4:0]           write_latency,
    output logic                 ack,
    // Memory side
    input  wire logic            mem_ck,
    output dmc_pkg::dmc_cmd_s    cmd,
    output logic                 cke,
    output logic                 odt
);
    import dmc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Link clock edge detection
    logic [1:0]  ck_sync;
    logic        ck_last;
    logic        ck_rise;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ck_sync <= `DMC_SYNC_RST;
            ck_last <= 1'b0;
        end else if (ce) begin
            ck_sync <= {ck_sync[0], mem_ck};
            ck_last <= ck_sync[1];
        end
    end
    assign ck_rise = ck_sync[1] & ~ck_last;

    ////////////////////////////////////////////////////////////////////////////
    // Field packing
    function automatic logic [12:0] pack_mr1(input dmc_cfg_s c);
        logic [12:0] a;
        a = 13'h0000;
        a[`DMC_MR1_DLL_DIS] = c.dll_off;
        a[`DMC_MR1_DRV_LO] = c.drive_strength[0];
        a[`DMC_MR1_DRV_HI] = c.drive_strength[1];
        a[`DMC_MR1_AL_LO +: 2] = c.additive_latency;
        a[`DMC_MR1_WLVL] = c.write_level;
        a[`DMC_MR1_QOFF] = c.output_off;
        if (!c.dll_off) begin
            a[`DMC_MR1_RTT_LO] = c.rtt_nom[0];
            a[`DMC_MR1_RTT_MID] = c.rtt_nom[1];
            a[`DMC_MR1_RTT_HI] = c.rtt_nom[2];
        end
        return a;
    endfunction

    function automatic logic [12:0] pack_mr2(input dmc_cfg_s c);
        logic [12:0] a;
        a = 13'h0000;
        a[`DMC_MR2_PARTIAL_ARRAY_SELF_REFRESH_LO +: 3] = c.partial_array_self_refresh;
        a[`DMC_MR2_CWL_LO +: 3] = c.cas_write_latency;
        a[`DMC_MR2_SRT] = c.self_refresh_temp_range;
        a[`DMC_MR2_RTTWR_LO +: 2] = c.dll_off ? 2'h0 : c.rtt_wr;
        return a;
    endfunction

    function automatic dmc_cmd_s mrs(input logic [2:0] ba, input logic [12:0] a);
        dmc_cmd_s m;
        m.cs_n = 1'b0;
        m.ras_n = 1'b0;
        m.cas_n = 1'b0;
        m.we_n = 1'b0;
        m.ba = ba;
        m.addr = a;
        return m;
    endfunction

    localparam dmc_cmd_s NOP = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                 ba: 3'h0, addr: 13'h0000};

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    dmc_state_e  state;
    dmc_cfg_s    held;
    logic [15:0] lock_cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= DMC_IDLE;
            held <= '0;
            cmd <= NOP;
            lock_cnt <= 16'h0000;
            ack <= 1'b0;
        end else if (ce) begin
            ack <= 1'b0;
            case (state)
                DMC_IDLE: begin
                    if (start) begin
                        held <= cfg;
                        state <= DMC_WAIT;
                    end
                end
                DMC_WAIT: begin
                    if (ck_rise) begin
                        cmd <= mrs(`DMC_BA_MR2, pack_mr2(held));
                        state <= DMC_MR1;
                    end
                end
                DMC_MR1: begin
                    if (ck_rise) begin
                        cmd <= mrs(`DMC_BA_MR1, pack_mr1(held));
                        state <= DMC_MR2;
                    end
                end
                DMC_MR2: begin
                    if (ck_rise) begin
                        cmd <= NOP;
                        lock_cnt <= LOCK_CYCLES[15:0];
                        state <= held.dll_off ? DMC_IDLE : DMC_LOCK;
                        ack <= held.dll_off;
                    end
                end
                DMC_LOCK: begin
                    if (ck_rise) begin
                        lock_cnt <= lock_cnt - 16'h0001;
                        if (lock_cnt == 16'h0001) begin
                            state <= DMC_IDLE;
                            ack <= 1'b1;
                        end
                    end
                end
                default: state <= DMC_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status and pins
    logic dll_ready;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dll_ready <= 1'b0;
            read_latency <= 5'h00;
            write_latency <= 5'h00;
        end else if (ce) begin
            if (state != DMC_IDLE) begin
                dll_ready <= 1'b0;
            end else if (ack) begin
                dll_ready <= ~held.dll_off;
            end
            read_latency <= 5'({1'b0, cas_latency}) + 5'({3'h0, held.additive_latency});
            write_latency <= 5'h05 + 5'({2'h0, held.cas_write_latency})
                             + 5'({3'h0, held.additive_latency});
        end
    end
    assign busy = (state != DMC_IDLE);
    assign ready = dll_ready & ~busy;
    assign cke = 1'b1;
    assign odt = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence mr2_then_mr1;
        cmd.ba == `DMC_BA_MR2 && !cmd.cs_n ##[1:40] cmd.ba == `DMC_BA_MR1 && !cmd.cs_n;
    endsequence
    mr2_bank_a: assert property (@(posedge clk) disable iff (rst)
        $rose(state == DMC_MR1) |-> cmd.ba == `DMC_BA_MR2 && !cmd.we_n && !cmd.ras_n)
        else $error("second register select wrong");
    mr1_order_a: assert property (@(posedge clk) disable iff (rst)
        $rose(state == DMC_MR1) |-> mr2_then_mr1)
        else $error("first register not written after second");
    dll_off_rtt_a: assert property (@(posedge clk) disable iff (rst)
        !cmd.cs_n && cmd.ba == `DMC_BA_MR1 && cmd.addr[`DMC_MR1_DLL_DIS]
        |-> !cmd.addr[`DMC_MR1_RTT_LO] && !cmd.addr[`DMC_MR1_RTT_MID]
            && !cmd.addr[`DMC_MR1_RTT_HI])
        else $error("nominal termination with DLL off");
    dll_off_wr_a: assert property (@(posedge clk) disable iff (rst)
        !cmd.cs_n && cmd.ba == `DMC_BA_MR2 && held.dll_off
        |-> cmd.addr[`DMC_MR2_RTTWR_LO +: 2] == 2'h0)
        else $error("write termination with DLL off");
    lock_wait_a: assert property (@(posedge clk) disable iff (rst)
        state == DMC_LOCK |-> !ready && cke)
        else $error("ready during lock wait");
    cke_hold_a: assert property (@(posedge clk) disable iff (rst)
        busy |-> cke)
        else $error("clock enable dropped");
    drive_bits_a: assert property (@(posedge clk) disable iff (rst)
        !cmd.cs_n && cmd.ba == `DMC_BA_MR1
        |-> cmd.addr[`DMC_MR1_DRV_HI] == held.drive_strength[1]
            && cmd.addr[`DMC_MR1_DRV_LO] == held.drive_strength[0])
        else $error("drive strength bits wrong");
    qoff_bit_a: assert property (@(posedge clk) disable iff (rst)
        !cmd.cs_n && cmd.ba == `DMC_BA_MR1 |-> cmd.addr[`DMC_MR1_QOFF] == held.output_off)
        else $error("output disable bit wrong");
    cfg_hold_a: assert property (@(posedge clk) disable iff (rst)
        busy && ce |=> $stable(held))
        else $error("held settings changed mid sequence");
    // Latencies are registered, so compare against the inputs of the enabled edge
    rl_sum_a: assert property (@(posedge clk) disable iff (rst)
        ce |=> read_latency == 5'({1'b0, $past(cas_latency)})
                               + 5'({3'h0, $past(held.additive_latency)}))
        else $error("read latency not AL plus CL");
    wl_sum_a: assert property (@(posedge clk) disable iff (rst)
        ce |=> write_latency == 5'h05 + 5'({2'h0, $past(held.cas_write_latency)})
                                + 5'({3'h0, $past(held.additive_latency)}))
        else $error("write latency not AL plus CAS_WRITE_LATENCY");
    ack_pulse_a: assert property (@(posedge clk) disable iff (rst)
        ack && ce |=> !ack)
        else $error("ack longer than one cycle");
    idle_nop_a: assert property (@(posedge clk) disable iff (rst)
        state == DMC_IDLE |-> cmd.cs_n)
        else $error("command issued while idle");
    mrs_form_a: assert property (@(posedge clk) disable iff (rst)
        !cmd.cs_n |-> !cmd.ras_n && !cmd.cas_n && !cmd.we_n
                      && (cmd.ba == `DMC_BA_MR1 || cmd.ba == `DMC_BA_MR2))
        else $error("command is not a mode register write");
    mr1_dll_a: assert property (@(posedge clk) disable iff (rst)
        !cmd.cs_n && cmd.ba == `DMC_BA_MR1 |-> cmd.addr[`DMC_MR1_DLL_DIS] == held.dll_off)
        else $error("DLL disable bit wrong");
    mr1_al_a: assert property (@(posedge clk) disable iff (rst)
        !cmd.cs_n && cmd.ba == `DMC_BA_MR1
        |-> cmd.addr[`DMC_MR1_AL_LO +: 2] == held.additive_latency)
        else $error("additive latency bits wrong");
    mr1_wlvl_a: assert property (@(posedge clk) disable iff (rst)
        !cmd.cs_n && cmd.ba == `DMC_BA_MR1 |-> cmd.addr[`DMC_MR1_WLVL] == held.write_level)
        else $error("write leveling bit wrong");
    mr2_cwl_a: assert property (@(posedge clk) disable iff (rst)
        !cmd.cs_n && cmd.ba == `DMC_BA_MR2
        |-> cmd.addr[`DMC_MR2_CWL_LO +: 3] == held.cas_write_latency)
        else $error("write latency code wrong");
    mr2_zero_a: assert property (@(posedge clk) disable iff (rst)
        !cmd.cs_n && cmd.ba == `DMC_BA_MR2
        |-> cmd.addr[12:11] == 2'h0 && !cmd.addr[8] && !cmd.addr[6])
        else $error("reserved bits set in second register");
    odt_off_a: assert property (@(posedge clk) disable iff (rst)
        held.dll_off |-> !odt)
        else $error("termination pin high with DLL off");
    lock_load_a: assert property (@(posedge clk) disable iff (rst)
        $rose(state == DMC_LOCK) |-> lock_cnt == LOCK_CYCLES[15:0])
        else $error("lock counter not loaded");
    // Last counted link edge of the lock wait
    sequence lock_done;
        state == DMC_LOCK && ce && ck_rise && lock_cnt == 16'h0001;
    endsequence
    lock_end_a: assert property (@(posedge clk) disable iff (rst)
        lock_done |=> ack && state == DMC_IDLE)
        else $error("lock wait did not end");
    ready_dll_a: assert property (@(posedge clk) disable iff (rst)
        ready |-> !held.dll_off)
        else $error("ready with DLL off");
endmodule

//--- dmc_defs.svh
// Constants for the DDR3 mode-register host controller
`ifndef DMC_DEFS_SVH
`define DMC_DEFS_SVH
// Bank codes selecting the target mode register
`define DMC_BA_MR0          3'h0
`define DMC_BA_MR1          3'h1
`define DMC_BA_MR2          3'h2
// Address bit positions, first mode register
`define DMC_MR1_DLL_DIS     0
`define DMC_MR1_DRV_LO      1
`define DMC_MR1_RTT_LO      2
`define DMC_MR1_AL_LO       3
`define DMC_MR1_DRV_HI      5
`define DMC_MR1_RTT_MID     6
`define DMC_MR1_WLVL        7
`define DMC_MR1_RTT_HI      9
`define DMC_MR1_QOFF        12
// Address bit positions, second mode register
`define DMC_MR2_PARTIAL_ARRAY_SELF_REFRESH_LO     0
`define DMC_MR2_CWL_LO      3
`define DMC_MR2_SRT         7
`define DMC_MR2_RTTWR_LO    9
// Address bit positions, zeroth mode register
`define DMC_MR0_DLL_RST     8
// Lock wait in memory clocks
`define DMC_DLL_LOCK_TIME   16'h0200
// Reset value of the link clock synchroniser
`define DMC_SYNC_RST        2'h0
`endif

//--- dmc_pkg.sv
// Types for the DDR3 mode-register host controller
package dmc_pkg;
    typedef struct packed {
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [2:0]  ba;
        logic [12:0] addr;
    } dmc_cmd_s;

    typedef struct packed {
        logic       dll_off;
        logic [1:0] drive_strength;
        logic [2:0] rtt_nom;
        logic [1:0] additive_latency;
        logic       write_level;
        logic       output_off;
        logic [1:0] rtt_wr;
        logic [2:0] cas_write_latency;
        logic       self_refresh_temp_range;
        logic [2:0] partial_array_self_refresh;
    } dmc_cfg_s;

    typedef enum logic [4:0] {
        DMC_IDLE = 5'b0_0001,
        DMC_WAIT = 5'b0_0010,
        DMC_MR1  = 5'b0_0100,
        DMC_MR2  = 5'b0_1000,
        DMC_LOCK = 5'b1_0000
    } dmc_state_e;
endpackage

//--- dmc_mem_model.sv
// Behavioural DDR3 device model that decodes mode-register writes
`include "dmc_defs.svh"
module dmc_mem_model
    import dmc_pkg::*;
(
    // Memory pins
    input  wire logic              mem_ck,
    input  wire dmc_pkg::dmc_cmd_s cmd,
    input  wire logic              cke,
    input  wire logic              odt,
    // Observed device state
    output dmc_pkg::dmc_cfg_s      regs,
    output logic [5:0]             order,
    output int                     since_mr1,
    output logic                   dll_on,
    output logic                   dq_hiz,
    output logic                   wr_term
);
    logic mrs;

    assign mrs = cke && !cmd.cs_n && !cmd.ras_n && !cmd.cas_n && !cmd.we_n;
    assign dll_on = !regs.dll_off;
    assign dq_hiz = regs.output_off;
    assign wr_term = odt && (regs.rtt_wr != 2'h0);

    initial begin
        regs = '0;
        order = '0;
        since_mr1 = 0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Commands are taken on the rising memory clock edge
    always @(posedge mem_ck) begin
        since_mr1 <= since_mr1 + 1;
        if (mrs) begin
            order <= {order[2:0], cmd.ba};
            case (cmd.ba)
                `DMC_BA_MR1: begin
                    regs.dll_off <= cmd.addr[0];
                    regs.drive_strength <= {cmd.addr[5], cmd.addr[1]};
                    regs.rtt_nom <= {cmd.addr[9], cmd.addr[6], cmd.addr[2]};
                    regs.additive_latency <= cmd.addr[4:3];
                    regs.write_level <= cmd.addr[7];
                    regs.output_off <= cmd.addr[12];
                    since_mr1 <= 0;
                end
                `DMC_BA_MR2: begin
                    regs.rtt_wr <= cmd.addr[10:9];
                    regs.cas_write_latency <= cmd.addr[5:3];
                    regs.self_refresh_temp_range <= cmd.addr[7];
                    regs.partial_array_self_refresh <= cmd.addr[2:0];
                end
                default: begin
                end
            endcase
        end
    end
endmodule

//--- test_dram_mode_reg_dll_odt_ctrl.sv
// Self-checking bench for the mode-register host controller
`include "dmc_defs.svh"
`define TB_CHK(got, exp) begin compares++; if ((got) !== (exp)) begin errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_dram_mode_reg_dll_odt_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    import dmc_pkg::*;
    localparam int LOCK = 4;
    logic       clk = 0, rst = 1, ce = 1, start = 0, mem_ck = 0;
    logic [3:0] cl = 4'h5;
    logic [4:0] rl, wl;
    logic [5:0] order;
    logic       busy, ready, ack, cke, odt;
    logic       dll_on, dq_hiz, wr_term;
    dmc_cfg_s   cfg = '0, exp, regs;
    dmc_cmd_s   cmd;
    int         since, n, errors = 0, compares = 0;

    dmc_ctrl #(.LOCK_CYCLES(LOCK)) dmc_ctrl_i (.clk(clk), .rst(rst), .ce(ce), .start(start),
        .cfg(cfg), .cas_latency(cl), .busy(busy), .ready(ready), .read_latency(rl),
        .write_latency(wl), .ack(ack), .mem_ck(mem_ck), .cmd(cmd), .cke(cke), .odt(odt));
    dmc_mem_model dmc_mem_model_i (.mem_ck(mem_ck), .cmd(cmd), .cke(cke), .odt(odt),
        .regs(regs), .order(order), .since_mr1(since), .dll_on(dll_on), .dq_hiz(dq_hiz),
        .wr_term(wr_term));

    ////////////////////////////////////////////////////////////////////////
    initial forever #2 clk = ~clk;
    initial begin
        #5;
        forever #16 mem_ck = ~mem_ck;
    end

    function automatic logic [4:0] exp_rl(input logic [3:0] c, input logic [1:0] a);
        return 5'(c) + 5'(a);
    endfunction

    function automatic logic [4:0] exp_wl(input logic [2:0] c, input logic [1:0] a);
        return 5'h5 + 5'(c) + 5'(a);
    endfunction

    task automatic results();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // One programming sequence; a second start while busy must be ignored
    task automatic run_seq(input int i);
        @(negedge clk);
        start = 1;
        @(negedge clk);
        start = 0;
        n = 0;
        while (ack !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
            start = (n == 10);
            if (i % 2 == 1)
                ce = ($urandom_range(3) != 0);
        end
        start = 0;
        ce = 1;
        if (n >= 3000)
            errors++;
        exp = cfg;
        if (cfg.dll_off) begin
            exp.rtt_nom = '0;
            exp.rtt_wr = '0;
        end
        `TB_CHK(regs, exp)
        `TB_CHK(order, {`DMC_BA_MR2, `DMC_BA_MR1})
        `TB_CHK(rl, exp_rl(cl, cfg.additive_latency))
        `TB_CHK(wl, exp_wl(cfg.cas_write_latency, cfg.additive_latency))
        `TB_CHK((cfg.dll_off || since >= LOCK), 1'b1)
        `TB_CHK(dll_on, ~cfg.dll_off)
        `TB_CHK(dq_hiz, cfg.output_off)
        `TB_CHK(wr_term, 1'b0)
        repeat (20) @(negedge clk);
        `TB_CHK(busy, 1'b0)
        `TB_CHK(ready, ~cfg.dll_off)
        `TB_CHK(cke, 1'b1)
        `TB_CHK(odt, 1'b0)
        `TB_CHK(regs, exp)
        $display("test %0d done", i);
    endtask

    initial begin
        void'($urandom(32'h0000_db49));
        repeat (12) @(negedge clk);
        rst = 0;
        for (int i = 0; i < 10; i++) begin
            cfg = 19'($urandom);
            cl = 4'(5 + $urandom_range(9));
            if (cfg.additive_latency == 2'h3)
                cfg.additive_latency = 2'h0;
            if (i == 0) begin
                cfg.dll_off = 1;
                cfg.rtt_nom = 3'h7;
                cfg.rtt_wr = 2'h3;
            end
            if (i == 1) begin
                cfg.dll_off = 0;
                cfg.additive_latency = 2'h2;
                cfg.cas_write_latency = 3'h7;
                cl = 4'he;
            end
            run_seq(i);
        end
        results();
    end

    // Watchdog far beyond the expected run length
    initial begin
        #100_000;
        errors++;
        results();
    end
endmodule
